// [hdl/serdes_test_power_control.v]
// Power, loss-of-signal, pattern test, loopback and start-up control of a 16-bit serializer
`include "serdes_test_defs.vh"

module serdes_test_power_control #(
    parameter POR_CYCLES  = `POR_CYCLES,
    parameter LOCK_CYCLES = `PLL_LOCK_CYCLES,
    parameter BIST_WORDS  = `BIST_GOOD_WORDS
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        chip_enable,
    input  wire        loopback_enable,
    input  wire        pattern_test_enable,
    input  wire [15:0] tx_data,
    input  wire        tx_low_byte_ctrl_flag,
    input  wire        tx_high_byte_ctrl_flag,
    output reg  [19:0] serial_out_pos,
    output reg  [19:0] serial_out_neg,
    output wire        serial_out_oe,
    input  wire [19:0] serial_in,
    input  wire        rx_signal_ok,
    output reg  [15:0] rx_data,
    output wire        rx_data_oe,
    output reg         rx_low_byte_ctrl_flag,
    output wire        rx_low_byte_ctrl_flag_oe,
    output reg         rx_high_byte_flag_or_signal_lost,
    output wire        rx_high_byte_flag_or_signal_lost_oe,
    output reg         rx_word_clk,
    output wire        pll_locked
);

    // Next sequence state and 20 generated bits, oldest bit in bit 0 (sent first)
    function [26:0] prbs_step;
        input [6:0] s_in;
        reg   [6:0] s;
        reg   [19:0] w;
        reg         nb;
        integer     i;
        begin
            s = s_in;
            w = 20'h00000;
            for (i = 0; i < 20; i = i + 1)
            begin
                nb = s[6] ^ s[5];
                w[i] = nb;
                s = {s[5:0], nb};
            end
            prbs_step = {s, w};
        end
    endfunction

    // Self-synchronising check: each bit must equal the taps of the seven before it
    function [7:0] prbs_check;
        input [6:0]  h_in;
        input [19:0] w;
        reg   [6:0]  h;
        reg          err;
        integer      i;
        begin
            h = h_in;
            err = 1'b0;
            for (i = 0; i < 20; i = i + 1)
            begin
                err = err | (w[i] ^ h[6] ^ h[5]);
                h = {h[5:0], w[i]};
            end
            prbs_check = {h, err};
        end
    endfunction

    // True on the last cycle of a count that runs from zero to limit - 1
    function count_done;
        input [15:0] cnt;
        input [15:0] limit;
        begin
            count_done = (cnt == limit - 16'h0001);
        end
    endfunction

    reg  [2:0]  ctrl_r;
    reg  [15:0] por_cnt_r;
    reg         por_busy_r;
    reg  [15:0] lock_cnt_r;
    reg         locked_r;
    reg  [6:0]  gen_r;
    reg  [6:0]  hist_r;
    reg         chk_valid_r;
    reg  [7:0]  good_cnt_r;
    reg         bist_pass_r;
    reg         pat_err_r;
    reg  [15:0] err_cnt_r;
    reg  [19:0] tx_word_r;
    reg  [7:0]  addr_r;
    reg         wr_r;
    reg         rd_r;
    reg         prime_r;
    reg  [31:0] rd_val;

    // Pins and register bits are ORed, so either side can force a mode
    wire        powered_down = ~chip_enable | ctrl_r[`CTRL_FORCE_PD];
    wire        loop_mode    = loopback_enable | ctrl_r[`CTRL_FORCE_LOOP];
    wire        pat_mode     = pattern_test_enable | ctrl_r[`CTRL_FORCE_PAT];
    wire        bist_mode    = pat_mode & loop_mode;
    // Level detector output is trusted as is; internal loopback never loses signal
    wire        signal_lost  = ~rx_signal_ok & ~loop_mode;
    wire [26:0] gen_nxt      = prbs_step(gen_r);
    wire [19:0] rx_word      = loop_mode ? tx_word_r : serial_in;
    wire [7:0]  chk_nxt      = prbs_check(hist_r, rx_word);
    // Two words after entering pattern mode only prime the history:
    // in loopback the first generated word reaches the checker one cycle late
    wire        word_err     = pat_mode & chk_valid_r & chk_nxt[0];
    // Only NONSEQ or SEQ transfers while the bus is ready are taken
    wire        bus_req      = hsel & hready & htrans[1];
    wire        clr_err      = wr_r & (addr_r == `REG_ERRCNT);
    wire        clr_stat     = wr_r & (addr_r == `REG_STATUS) & hwdata[`ST_PAT_ERR];

    // Registers answer in one cycle, so the slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign pll_locked = locked_r;

    // Start-up floats all the drivers; power-down floats all but the high-byte flag / signal-lost output
    assign serial_out_oe = ~powered_down & ~loop_mode & ~por_busy_r;
    assign rx_data_oe = ~powered_down & ~por_busy_r;
    assign rx_low_byte_ctrl_flag_oe = ~powered_down & ~por_busy_r;
    assign rx_high_byte_flag_or_signal_lost_oe = ~por_busy_r;

    // Power-on reset: a fixed count of reference cycles, so its length follows the clock
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            por_cnt_r <= 16'h0000;
            por_busy_r <= 1'b1;
        end
        else if (por_busy_r)
        begin
            if (count_done(por_cnt_r, POR_CYCLES[15:0]))
                por_busy_r <= 1'b0;
            else
                por_cnt_r <= por_cnt_r + 16'h0001;
        end
    end

    // Clock multiplier lock; reference keeps running in power-down so lock is kept
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            lock_cnt_r <= 16'h0000;
            locked_r <= 1'b0;
        end
        else if (!locked_r)
        begin
            if (count_done(lock_cnt_r, LOCK_CYCLES[15:0]))
                locked_r <= 1'b1;
            else
                lock_cnt_r <= lock_cnt_r + 16'h0001;
        end
    end

    // Transmit: inputs taken on the rising edge; one word stands for twenty line bits
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_word_r <= 20'h00000;
            gen_r <= `PRBS_SEED;
            serial_out_pos <= 20'h00000;
            serial_out_neg <= 20'hFFFFF;
        end
        else
        begin
            // Pattern mode ignores the host word entirely
            if (pat_mode)
            begin
                tx_word_r <= gen_nxt[19:0];
                gen_r <= gen_nxt[26:20];
            end
            else
            begin
                tx_word_r <= {1'b0, tx_high_byte_ctrl_flag, tx_data[15:8],
                              1'b0, tx_low_byte_ctrl_flag, tx_data[7:0]};
            end
            // Twenty bits per reference cycle equals ten bit-clock periods, both edges
            serial_out_pos <= tx_word_r;
            // Complement registered alongside so both legs switch on the same edge
            serial_out_neg <= ~tx_word_r;
        end
    end

    // Pattern checker and self-test status
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hist_r <= 7'h00;
            prime_r <= 1'b0;
            chk_valid_r <= 1'b0;
            good_cnt_r <= 8'h00;
            bist_pass_r <= 1'b0;
            pat_err_r <= 1'b0;
            err_cnt_r <= 16'h0000;
        end
        else
        begin
            hist_r <= chk_nxt[7:1];
            prime_r <= pat_mode;
            chk_valid_r <= pat_mode & prime_r;
            // Leaving self-test drops the pass status, so a new run starts from zero
            if (!bist_mode || word_err)
            begin
                good_cnt_r <= 8'h00;
                bist_pass_r <= 1'b0;
            end
            else if (chk_valid_r)
            begin
                if (good_cnt_r == BIST_WORDS[7:0] - 8'h01)
                    bist_pass_r <= 1'b1;
                else
                    good_cnt_r <= good_cnt_r + 8'h01;
            end
            // An error in the clearing cycle keeps the flag set
            if (word_err)
                pat_err_r <= 1'b1;
            else if (clr_stat)
                pat_err_r <= 1'b0;
            if (word_err)
            begin
                // Saturates rather than wraps so a long run still reads as failing
                if (err_cnt_r != 16'hFFFF)
                    err_cnt_r <= err_cnt_r + 16'h0001;
            end
            else if (clr_err)
                err_cnt_r <= 16'h0000;
        end
    end

    // Receive outputs: loss forces all ones, pattern mode puts the check result on the low flag
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_data <= 16'hFFFF;
            rx_low_byte_ctrl_flag <= 1'b0;
            rx_high_byte_flag_or_signal_lost <= 1'b0;
            rx_word_clk <= 1'b0;
        end
        else
        begin
            rx_word_clk <= por_busy_r ? 1'b0 : ~rx_word_clk;
            if (signal_lost)
            begin
                rx_data <= 16'hFFFF;
                rx_low_byte_ctrl_flag <= 1'b1;
                rx_high_byte_flag_or_signal_lost <= 1'b1;
            end
            else
            begin
                rx_data <= {rx_word[17:10], rx_word[7:0]};
                rx_high_byte_flag_or_signal_lost <= rx_word[18];
                // Self-test: flag rises only once enough clean words have passed
                if (bist_mode)
                    rx_low_byte_ctrl_flag <= bist_pass_r & ~word_err;
                else if (pat_mode)
                    rx_low_byte_ctrl_flag <= ~word_err;
                else
                    rx_low_byte_ctrl_flag <= rx_word[8];
            end
        end
    end

    // Read mux on the address phase's own address
    always @*
    begin
        case (haddr[7:0])
            `REG_CTRL:
                rd_val = {29'h00000000, ctrl_r};
            `REG_STATUS:
                rd_val = {26'h0000000, pat_err_r, bist_pass_r, signal_lost,
                          locked_r, por_busy_r, powered_down};
            `REG_ERRCNT:
                rd_val = {16'h0000, err_cnt_r};
            default:
                rd_val = 32'h00000000;
        endcase
    end

    // AHB-Lite slave, zero wait states; read data registered in the address phase
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_r <= 8'h00;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            ctrl_r <= `CTRL_RESET;
            hrdata <= 32'h00000000;
        end
        else
        begin
            wr_r <= bus_req & hwrite;
            rd_r <= bus_req & ~hwrite;
            if (bus_req)
                addr_r <= haddr[7:0];
            if (wr_r && addr_r == `REG_CTRL)
                ctrl_r <= hwdata[2:0];
            // Read data stands only in the data phase, zero otherwise
            if (bus_req && !hwrite)
                hrdata <= rd_val;
            else
                hrdata <= 32'h00000000;
        end
    end

endmodule // serdes_test_power_control

// [inc/serdes_test_defs.vh]
// Constants for the serializer test and power control block
`ifndef SERDES_TEST_DEFS_VH
`define SERDES_TEST_DEFS_VH

`define CLK_MHZ           50
`define POR_MAX_US        1000
`define PLL_LOCK_NOM_US   100
`define PLL_LOCK_MAX_US   400
`define RX_AMPL_MIN_MV    200
`define PLL_LOCK_CYCLES   (`PLL_LOCK_NOM_US * `CLK_MHZ)
`define POR_CYCLES        16384
`define BIST_GOOD_WORDS   127

`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_ERRCNT        8'h08

`define CTRL_FORCE_PD     0
`define CTRL_FORCE_LOOP   1
`define CTRL_FORCE_PAT    2
`define CTRL_RESET        3'h0

`define ST_POWERED_DOWN   0
`define ST_POR_BUSY       1
`define ST_PLL_LOCKED     2
`define ST_SIGNAL_LOST    3
`define ST_BIST_PASS      4
`define ST_PAT_ERR        5

`define PRBS_SEED         7'h7F
`define WORD_W            20

`endif

// [tb/serdes_checker.sv]
// Port assertions for the serializer test and power control block
module serdes_checker #(
    parameter POR_CYCLES  = 16,
    parameter LOCK_CYCLES = 8
) (
    input wire        hclk,
    input wire        hresetn,
    input wire        chip_enable,
    input wire        loopback_enable,
    input wire        pattern_test_enable,
    input wire [15:0] tx_data,
    input wire        tx_low_byte_ctrl_flag,
    input wire        tx_high_byte_ctrl_flag,
    input wire [19:0] serial_out_pos,
    input wire        serial_out_oe,
    input wire [19:0] serial_in,
    input wire        rx_signal_ok,
    input wire [15:0] rx_data,
    input wire        rx_data_oe,
    input wire        rx_low_byte_ctrl_flag,
    input wire        rx_high_byte_flag_or_signal_lost,
    input wire        rx_high_byte_flag_or_signal_lost_oe,
    input wire        rx_word_clk,
    input wire        pll_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_r;
    // Edges since reset release, saturating so long runs do not wrap
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_r <= 16'h0000;
        else if (cnt_r != 16'hFFFF)
            cnt_r <= cnt_r + 16'h0001;
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    pd_float_a: assert property (
        !chip_enable && !$past(chip_enable) |-> !serial_out_oe && !rx_data_oe) else $error("power down drives");
    loop_float_a: assert property (
        loopback_enable && $past(loopback_enable) |-> !serial_out_oe) else $error("loopback drives line");
    loss_high_a: assert property (
        !rx_signal_ok && !loopback_enable && !pattern_test_enable |=> !rx_data_oe
        || (rx_data == 16'hFFFF && rx_low_byte_ctrl_flag && rx_high_byte_flag_or_signal_lost)) else $error("loss");
    rx_word_a: assert property (
        rx_signal_ok && !loopback_enable && !pattern_test_enable && !$past(pattern_test_enable) |=> !rx_data_oe
        || (rx_data == {$past(serial_in[17:10]), $past(serial_in[7:0])}
        && rx_low_byte_ctrl_flag == $past(serial_in[8])
        && rx_high_byte_flag_or_signal_lost == $past(serial_in[18]))) else $error("rx word");
    tx_word_a: assert property (
        !$past(pattern_test_enable) && !pattern_test_enable ##1 !pattern_test_enable |=> !serial_out_oe
        || serial_out_pos == {1'b0, $past(tx_high_byte_ctrl_flag, 2), $past(tx_data[15:8], 2), 1'b0,
        $past(tx_low_byte_ctrl_flag, 2), $past(tx_data[7:0], 2)}) else $error("tx word");
    por_hold_a: assert property (
        cnt_r < POR_CYCLES - 1 |-> !rx_data_oe && !rx_high_byte_flag_or_signal_lost_oe && !rx_word_clk)
        else $error("por outputs");
    por_end_a: assert property (
        cnt_r == POR_CYCLES + 2 |-> rx_high_byte_flag_or_signal_lost_oe) else $error("por too long");
    pll_lock_a: assert property (
        cnt_r < LOCK_CYCLES - 1 && pll_locked || cnt_r > LOCK_CYCLES + 2 && !pll_locked |-> 1'b0)
        else $error("lock time");
    word_clk_a: assert property (
        cnt_r > POR_CYCLES + 2 && rx_data_oe && $past(rx_data_oe) |-> rx_word_clk != $past(rx_word_clk))
        else $error("word clock");
    cover property (loopback_enable && pattern_test_enable ##8 rx_low_byte_ctrl_flag);
    cover property (!rx_signal_ok ##1 rx_data == 16'hFFFF);
    cover property (!chip_enable ##1 !serial_out_oe);
endmodule // serdes_checker

// [tb/remote_link_model.sv]
// Far-end transceiver model that sends line words and can drop the signal
module remote_link_model (
    input  wire         hclk,
    input  wire         send,
    input  wire  [19:0] word,
    output logic [19:0] serial_in = 20'h00000,
    output logic        rx_signal_ok = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] junk_r = 20'h5A5A5;
    // A dead line carries a changing pattern, never the last word
    always @(posedge hclk)
    begin
        junk_r <= ~junk_r;
        rx_signal_ok <= send;
        serial_in <= send ? word : junk_r;
    end
endmodule // remote_link_model

// [tb/tb.sv]
// Self-checking bench for the serializer test and power control block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, chip_enable = 1, loopback_enable = 0;
    logic        pattern_test_enable = 0, tx_low_byte_ctrl_flag = 0, tx_high_byte_ctrl_flag = 0, link_on = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 3'h2;
    logic [15:0] tx_data = 0, rx_data;
    logic [19:0] far_word = 0, serial_out_pos, serial_out_neg, serial_in;
    logic        hreadyout, hresp, serial_out_oe, rx_signal_ok, rx_data_oe, rx_low_byte_ctrl_flag;
    logic        rx_low_byte_ctrl_flag_oe, rx_high_byte_flag_or_signal_lost, rx_high_byte_flag_or_signal_lost_oe;
    logic        rx_word_clk, pll_locked;
    wire         hready = hreadyout;
    int          failures = 0, comparisons = 0;
    serdes_test_power_control #(.POR_CYCLES(16), .LOCK_CYCLES(8), .BIST_WORDS(4)) i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .chip_enable(chip_enable), .loopback_enable(loopback_enable), .pattern_test_enable(pattern_test_enable),
        .tx_data(tx_data), .tx_low_byte_ctrl_flag(tx_low_byte_ctrl_flag),
        .tx_high_byte_ctrl_flag(tx_high_byte_ctrl_flag), .serial_out_pos(serial_out_pos),
        .serial_out_neg(serial_out_neg), .serial_out_oe(serial_out_oe), .serial_in(serial_in),
        .rx_signal_ok(rx_signal_ok), .rx_data(rx_data), .rx_data_oe(rx_data_oe),
        .rx_low_byte_ctrl_flag(rx_low_byte_ctrl_flag), .rx_low_byte_ctrl_flag_oe(rx_low_byte_ctrl_flag_oe),
        .rx_high_byte_flag_or_signal_lost(rx_high_byte_flag_or_signal_lost),
        .rx_high_byte_flag_or_signal_lost_oe(rx_high_byte_flag_or_signal_lost_oe),
        .rx_word_clk(rx_word_clk), .pll_locked(pll_locked));
    remote_link_model i_far (.hclk(hclk), .send(link_on), .word(far_word), .serial_in(serial_in),
                             .rx_signal_ok(rx_signal_ok));
    // Reference clock keeps running through power down
    initial forever #10 hclk = ~hclk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        rd = hrdata;
    endtask
    task tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task t_tx_rx;
        logic [19:0] exp_w;
        for (int i = 0; i < 4; i++)
        begin
            tx_data <= 16'hA50F ^ (16'h1111 * i);
            {tx_high_byte_ctrl_flag, tx_low_byte_ctrl_flag} <= i[1:0];
            far_word <= {1'b0, i[1], 8'hC3, 1'b0, i[0], 8'h3C};
            repeat (4) @(posedge hclk);
            exp_w = {1'b0, i[1], tx_data[15:8], 1'b0, i[0], tx_data[7:0]};
            chk("line", exp_w, serial_out_pos);
            chk("line_n", exp_w ^ 20'hFFFFF, serial_out_neg);
            chk("rx", {i[1:0], 16'hC33C}, {rx_high_byte_flag_or_signal_lost, rx_low_byte_ctrl_flag, rx_data});
        end
        link_on <= 0;
        repeat (3) @(posedge hclk);
        chk("loss", 18'h3FFFF, {rx_high_byte_flag_or_signal_lost, rx_low_byte_ctrl_flag, rx_data});
    endtask
    task t_loop;
        loopback_enable <= 1;
        tx_data <= 16'h9E61;
        repeat (5) @(posedge hclk);
        chk("loop", {1'b0, 16'h9E61}, {serial_out_oe, rx_data});
        pattern_test_enable <= 1;
        repeat (3) @(posedge hclk);
        chk("pending", 0, rx_low_byte_ctrl_flag);
        repeat (17) @(posedge hclk);
        ahb(8'h04, 0, 0);
        chk("bist", 32'h14, rd);
        chk("pass", 1, rx_low_byte_ctrl_flag);
        loopback_enable <= 0;
        link_on <= 1;
        far_word <= 20'h12345;
        repeat (8) @(posedge hclk);
        chk("bad", 0, rx_low_byte_ctrl_flag);
        pattern_test_enable <= 0;
        repeat (4) @(posedge hclk);
        ahb(8'h04, 0, 0);
        chk("err", 32'h24, rd);
        ahb(8'h08, 0, 0);
        chk("errcnt", 1, rd != 0);
        ahb(8'h08, 1, 32'h0);
        ahb(8'h04, 1, 32'h20);
        ahb(8'h04, 0, 0);
        chk("clr", 32'h04, rd);
        ahb(8'h08, 0, 0);
        chk("errcnt_clr", 0, rd);
    endtask
    task t_power;
        chip_enable <= 0;
        repeat (3) @(posedge hclk);
        chk("pd", 4'h1, {serial_out_oe, rx_data_oe, rx_low_byte_ctrl_flag_oe, rx_high_byte_flag_or_signal_lost_oe});
        chip_enable <= 1;
        ahb(8'h00, 1, 32'h1);
        ahb(8'h00, 0, 0);
        chk("ctrl", 32'h1, rd);
        chk("forced_pd", 0, serial_out_oe);
        chk("okay", 2'h1, {hresp, hreadyout});
        ahb(8'h00, 1, 32'h0);
        ahb(8'h0C, 0, 0);
        chk("unmapped", 0, rd);
        repeat (3) @(posedge hclk);
        chk("wake", 4'hF, {serial_out_oe, rx_data_oe, rx_low_byte_ctrl_flag_oe, rx_high_byte_flag_or_signal_lost_oe});
    endtask
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        repeat (2) @(posedge hclk);
        chk("por", 0, {rx_data_oe, rx_word_clk, pll_locked});
        repeat (30) @(posedge hclk);
        chk("ready", 2'h3, {rx_data_oe, pll_locked});
        t_tx_rx();
        t_loop();
        t_power();
        tally_and_finish();
    end
    initial
    begin
        #(20ns * 3000);
        failures++;
        tally_and_finish();
    end
endmodule // tb
bind serdes_test_power_control serdes_checker #(.POR_CYCLES(POR_CYCLES), .LOCK_CYCLES(LOCK_CYCLES)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .chip_enable(chip_enable), .loopback_enable(loopback_enable),
    .pattern_test_enable(pattern_test_enable), .tx_data(tx_data),
    .tx_low_byte_ctrl_flag(tx_low_byte_ctrl_flag), .tx_high_byte_ctrl_flag(tx_high_byte_ctrl_flag),
    .serial_out_pos(serial_out_pos), .serial_out_oe(serial_out_oe), .serial_in(serial_in),
    .rx_signal_ok(rx_signal_ok), .rx_data(rx_data), .rx_data_oe(rx_data_oe),
    .rx_low_byte_ctrl_flag(rx_low_byte_ctrl_flag),
    .rx_high_byte_flag_or_signal_lost(rx_high_byte_flag_or_signal_lost),
    .rx_high_byte_flag_or_signal_lost_oe(rx_high_byte_flag_or_signal_lost_oe),
    .rx_word_clk(rx_word_clk), .pll_locked(pll_locked));
